// *** rtl/label_select_map.svh ***
// offsets, field positions, reset values and widths for the label selector
`ifndef LABEL_SELECT_MAP_SVH
`define LABEL_SELECT_MAP_SVH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define OFS_MON_LO      8'h00
`define OFS_MON_HI      8'h04
`define OFS_HYP_LO      8'h08
`define OFS_HYP_HI      8'h0c
`define OFS_KER_LO      8'h10
`define OFS_KER_HI      8'h14
`define OFS_APP_LO      8'h18
`define OFS_APP_HI      8'h1c
`define OFS_FEAT        8'h20
`define OFS_CTRL        8'h24
`define OFS_VALID       8'h28
`define OFS_STATUS      8'h2c
`define OFS_MAP_BASE    8'h40
`define MAP_ADDR_MSB    8'h40
`define MAP_ADDR_MASK   8'hc0

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
// label word lo: [15:0] id data side, [31:16] id instr side
// label word hi: [7:0] group data side, [15:8] group instr side
`define CTRL_HYP_EN_BIT  0
`define CTRL_VIRT_BIT    1
`define FEAT_PID_LSB     0
`define FEAT_GRP_LSB     16
`define FEAT_VPM_LSB     24

// ------------------------------------------------------------
// reset values and defaults
// ------------------------------------------------------------
`define DEFAULT_PID     16'h0000
`define DEFAULT_GRP     8'h00
`define RST_PID_MAX     16'hffff
`define RST_GRP_MAX     8'hff
`define RST_VPM_MAX     3'h7
`define MAP_WORDS       8
`define MAP_ENTRIES     4

`endif

// *** rtl/label_select_pkg.sv ***
// types shared by the label selector files
package label_select_pkg;
   typedef logic [15:0] pid_t;
   typedef logic [7:0]  grp_t;

   // one access request from the processor path
   typedef struct packed {
      logic [1:0] level;
      logic       instr_side_select;
      logic       prior_err;
   } label_req_s;

   // labels presented back with the same access
   typedef struct packed {
      pid_t pid;
      grp_t grp;
      logic err;
   } label_rsp_s;

   // bus slave sequencing
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_e;
endpackage

// *** rtl/virt_map_store.sv ***
// eight 64-bit map words with registered bus read and comb lookup port
`timescale 1ns/1ps
`include "label_select_map.svh"
module virt_map_store #(
   parameter int WORDS = `MAP_WORDS
) (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        sys_rst_in,
   // bus side, 32-bit halves
   input  wire logic        wr_in,
   input  wire logic [3:0]  half_idx_in,
   input  wire logic [31:0] wdata_in,
   output logic      [31:0] rdata_out,
   // lookup side
   input  wire logic [15:0] vid_in,
   output logic      [15:0] entry_out
);
   import label_select_pkg::*;

   logic [63:0] virt_map_word [WORDS];
   logic [63:0] sel_word;
   logic [15:0] word_idx;

   // ------------------------------------------------------------
   // storage, one generate slot per map word
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WORDS; g++) begin : g_word
         always_ff @(posedge clk_sys_in) begin
            if (sys_rst_in) begin
               virt_map_word[g] <= 64'h0;
            end else if (wr_in && half_idx_in[3:1] == 3'(g)) begin
               if (half_idx_in[0]) begin
                  virt_map_word[g][63:32] <= wdata_in;
               end else begin
                  virt_map_word[g][31:0] <= wdata_in;
               end
            end
         end
      end
   endgenerate

   // registered bus read so software view stays off the comb path
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_out <= 32'h0;
      end else if (half_idx_in[0]) begin
         rdata_out <= virt_map_word[half_idx_in[3:1]][63:32];
      end else begin
         rdata_out <= virt_map_word[half_idx_in[3:1]][31:0];
      end
   end

   // word = vid div 4, missing words read as zero; no checks here
   always_comb begin
      word_idx = vid_in >> 2;
      if (word_idx < 16'(WORDS)) begin
         sel_word = virt_map_word[word_idx[2:0]];
      end else begin
         sel_word = 64'h0;
      end
      entry_out = sel_word[{vid_in[1:0], 4'h0} +: 16];
   end
endmodule

// *** rtl/label_bus_slave.sv ***
// avalon-mm slave front end: one wait cycle, then acknowledge
`timescale 1ns/1ps
module label_bus_slave (
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       sys_rst_in,
   // bus request
   input  wire logic       read_in,
   input  wire logic       write_in,
   // handshake
   output logic            waitrequest_out,
   output logic            ack_out
);
   import label_select_pkg::*;

   bus_state_e state_r;

   // every access waits one cycle so registered read data is ready
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_r <= BUS_IDLE;
      end else begin
         case (state_r)
            BUS_IDLE: begin
               if (read_in || write_in) begin
                  state_r <= BUS_ACK;
               end
            end
            BUS_ACK:  state_r <= BUS_IDLE;
            default:  state_r <= BUS_IDLE;
         endcase
      end
   end

   assign ack_out         = (state_r == BUS_ACK);
   assign waitrequest_out = !ack_out;
endmodule

// *** rtl/partition_label_select.sv ***
// partition id and group label selector with virtual id translation
//
// Contract
// - group label passes only if not above maximum, else default.
// - id comes from the requested level's register, instr or data field.
// - group label comes from the requested level's register, instr or data.
// - level 2 id uses hypervisor register only if enabled, else zero.
// - level 2 group uses hypervisor register only if enabled, else zero.
// - level 0 uses the application register, never the kernel fields.
// - map word index is virtual id divided by four.
// - map word index beyond the eighth word reads as all zeros.
// - entry is 16 bits at bit (virtual id mod 4) times 16.
// - map lookup does no checks; caller validates and reduces first.
// - ids are 16 bits, group labels 8 bits, both defaults zero.
// - id above maximum gives default plus error, before translation.
// - use valid entry, else valid entry 0, else default with error.
// - virtual max is 4 times count field plus 3; larger ids wrap.
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "label_select_map.svh"
module partition_label_select #(
   parameter int MAP_WORDS = `MAP_WORDS
) (
   // clock and reset
   input  wire logic                         clk_sys_in,
   input  wire logic                         sys_rst_in,
   // avalon-mm register slave
   input  wire logic [7:0]                   address_in,
   input  wire logic                         read_in,
   input  wire logic                         write_in,
   input  wire logic [31:0]                  writedata_in,
   output logic      [31:0]                  readdata_out,
   output logic                              waitrequest_out,
   // access request and labels
   input  wire label_select_pkg::label_req_s req_in,
   output label_select_pkg::label_rsp_s      rsp_out
);
   import label_select_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [63:0] monitor_level_label_reg_r;
   logic [63:0] hypervisor_label_reg_r;
   logic [63:0] kernel_label_reg_r;
   logic [63:0] application_label_reg_r;
   logic [31:0] label_feature_id_reg_r;
   logic [1:0]  ctrl_r;
   logic [31:0] virt_map_valid_bits_r;
   logic [31:0] rdata_r;
   logic [7:0]  err_count_r;
   logic        ack;
   logic        wr_go;
   logic        map_hit;
   logic [31:0] map_rdata;
   logic [15:0] map_entry;

   // unpacked feature fields
   pid_t        pid_max;
   grp_t        grp_max;
   logic [2:0]  map_register_count_field;
   logic        hyp_en;
   logic        virt_en;

   assign pid_max  = label_feature_id_reg_r[`FEAT_PID_LSB +: 16];
   assign grp_max  = label_feature_id_reg_r[`FEAT_GRP_LSB +: 8];
   assign map_register_count_field =
      label_feature_id_reg_r[`FEAT_VPM_LSB +: 3];
   assign hyp_en   = ctrl_r[`CTRL_HYP_EN_BIT];
   assign virt_en  = ctrl_r[`CTRL_VIRT_BIT];
   assign map_hit  = (address_in & `MAP_ADDR_MASK) == `MAP_ADDR_MSB;

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   label_bus_slave u_bus (
      .clk_sys_in      (clk_sys_in),
      .sys_rst_in      (sys_rst_in),
      .read_in         (read_in),
      .write_in        (write_in),
      .waitrequest_out (waitrequest_out),
      .ack_out         (ack)
   );

   // writes land only on the acknowledge edge
   assign wr_go = ack && write_in;

   // ------------------------------------------------------------
   // map word storage
   // ------------------------------------------------------------
   logic [15:0] vid_reduced;
   logic [15:0] vid_lookup;

   virt_map_store #(
      .WORDS (MAP_WORDS)
   ) u_map (
      .clk_sys_in  (clk_sys_in),
      .sys_rst_in  (sys_rst_in),
      .wr_in       (wr_go && map_hit),
      .half_idx_in (address_in[5:2]),
      .wdata_in    (writedata_in),
      .rdata_out   (map_rdata),
      .vid_in      (vid_lookup),
      .entry_out   (map_entry)
   );

   // label registers, written as 32-bit halves
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         monitor_level_label_reg_r <= 64'h0;
         hypervisor_label_reg_r    <= 64'h0;
         kernel_label_reg_r        <= 64'h0;
         application_label_reg_r   <= 64'h0;
      end else if (wr_go) begin
         case (address_in)
            `OFS_MON_LO: monitor_level_label_reg_r[31:0]  <= writedata_in;
            `OFS_MON_HI: monitor_level_label_reg_r[63:32] <= writedata_in;
            `OFS_HYP_LO: hypervisor_label_reg_r[31:0]     <= writedata_in;
            `OFS_HYP_HI: hypervisor_label_reg_r[63:32]    <= writedata_in;
            `OFS_KER_LO: kernel_label_reg_r[31:0]         <= writedata_in;
            `OFS_KER_HI: kernel_label_reg_r[63:32]        <= writedata_in;
            `OFS_APP_LO: application_label_reg_r[31:0]    <= writedata_in;
            `OFS_APP_HI: application_label_reg_r[63:32]   <= writedata_in;
            default: ;
         endcase
      end
   end

   // implemented maxima and control; maxima writable for bring-up
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         label_feature_id_reg_r <= {5'h0, `RST_VPM_MAX, `RST_GRP_MAX,
                                    `RST_PID_MAX};
         ctrl_r                 <= 2'h0;
         virt_map_valid_bits_r  <= 32'h0;
      end else if (wr_go) begin
         case (address_in)
            `OFS_FEAT:  label_feature_id_reg_r <= writedata_in;
            `OFS_CTRL:  ctrl_r                 <= writedata_in[1:0];
            `OFS_VALID: virt_map_valid_bits_r  <= writedata_in;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // label selection
   // ------------------------------------------------------------
   logic [63:0] lvl_reg;
   pid_t        reg_pid;
   grp_t        reg_grp;

   // pick the level's register; level 2 gated by hypervisor enable
   always_comb begin
      case (req_in.level)
         2'd3: lvl_reg = monitor_level_label_reg_r;
         2'd2: lvl_reg = hyp_en ? hypervisor_label_reg_r
                                : 64'h0;
         2'd1: lvl_reg = kernel_label_reg_r;
         2'd0: lvl_reg = application_label_reg_r;
         default: lvl_reg = 64'h0;
      endcase
      // instr side takes the upper field of each pair
      reg_pid = req_in.instr_side_select ? lvl_reg[31:16]
                                         : lvl_reg[15:0];
      reg_grp = req_in.instr_side_select ? lvl_reg[47:40]
                                         : lvl_reg[39:32];
   end

   // ------------------------------------------------------------
   // range check and virtual translation
   // ------------------------------------------------------------
   logic [16:0] vmax;
   pid_t        pid_out;
   logic        pid_err;
   logic        use_virt;

   // virtual only below the monitor level with hypervisor enabled
   assign use_virt = virt_en && hyp_en && (req_in.level != 2'd3);

   // reduce the virtual id; steer the one lookup port to entry 0 when
   // the mapped entry is invalid, so the map is never read a second way
   always_comb begin
      vmax        = {12'h0, map_register_count_field, 2'b11};
      vid_reduced = reg_pid;
      if ({1'b0, reg_pid} > vmax) begin
         vid_reduced = 16'(({1'b0, reg_pid} % (vmax + 17'd1)));
      end
      if (virt_map_valid_bits_r[vid_reduced[4:0]]) begin
         vid_lookup = vid_reduced;
      end else begin
         vid_lookup = 16'h0000;
      end
   end

   // range check first, translation only for ids that passed it
   always_comb begin
      pid_out = `DEFAULT_PID;
      pid_err = 1'b0;
      if (reg_pid > pid_max) begin
         pid_err = 1'b1;
      end else if (!use_virt) begin
         pid_out = reg_pid;
      end else begin
         if (virt_map_valid_bits_r[vid_reduced[4:0]]) begin
            pid_out = map_entry;
         end else if (virt_map_valid_bits_r[0]) begin
            pid_out = map_entry;
         end else begin
            pid_err = 1'b1;
         end
         if (pid_out > pid_max) begin
            pid_out = `DEFAULT_PID;
            pid_err = 1'b1;
         end
      end
   end

   // group label: error or out of range gives default
   grp_t grp_out;
   always_comb begin
      if (pid_err || req_in.prior_err) begin
         grp_out = `DEFAULT_GRP;
      end else if (reg_grp <= grp_max) begin
         grp_out = reg_grp;
      end else begin
         grp_out = `DEFAULT_GRP;
      end
   end

   assign rsp_out = '{pid: pid_out, grp: grp_out, err: pid_err};

   // ------------------------------------------------------------
   // status and read data
   // ------------------------------------------------------------
   // saturating count of id errors, visible to software
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         err_count_r <= 8'h0;
      end else if (pid_err && err_count_r != 8'hff) begin
         err_count_r <= err_count_r + 8'h01;
      end
   end

   // register mux; unmapped words read zero
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rdata_r <= 32'h0;
      end else begin
         case (address_in)
            `OFS_MON_LO: rdata_r <= monitor_level_label_reg_r[31:0];
            `OFS_MON_HI: rdata_r <= monitor_level_label_reg_r[63:32];
            `OFS_HYP_LO: rdata_r <= hypervisor_label_reg_r[31:0];
            `OFS_HYP_HI: rdata_r <= hypervisor_label_reg_r[63:32];
            `OFS_KER_LO: rdata_r <= kernel_label_reg_r[31:0];
            `OFS_KER_HI: rdata_r <= kernel_label_reg_r[63:32];
            `OFS_APP_LO: rdata_r <= application_label_reg_r[31:0];
            `OFS_APP_HI: rdata_r <= application_label_reg_r[63:32];
            `OFS_FEAT:   rdata_r <= label_feature_id_reg_r;
            `OFS_CTRL:   rdata_r <= {30'h0, ctrl_r};
            `OFS_VALID:  rdata_r <= virt_map_valid_bits_r;
            `OFS_STATUS: rdata_r <= {23'h0, pid_err, err_count_r};
            default:     rdata_r <= 32'h0;
         endcase
      end
   end

   assign readdata_out = map_hit ? map_rdata : rdata_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   grp_range_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (!pid_err && !req_in.prior_err && reg_grp > grp_max)
      |-> rsp_out.grp == 8'h00)
      else $error("group above max not defaulted");
   prior_err_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      req_in.prior_err |-> rsp_out.grp == 8'h00)
      else $error("prior error did not default group");
   pid_range_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (reg_pid > pid_max) |-> (rsp_out.err && rsp_out.pid == 16'h0))
      else $error("id above max not flagged");
   hyp_gate_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (req_in.level == 2'd2 && !hyp_en) |-> (reg_pid == 16'h0
       && reg_grp == 8'h00))
      else $error("disabled hypervisor level not zero");
   app_reg_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (req_in.level == 2'd0 && !req_in.instr_side_select)
      |-> reg_pid == application_label_reg_r[15:0])
      else $error("level 0 not from application register");
   side_pick_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (req_in.level == 2'd3 && req_in.instr_side_select)
      |-> (reg_pid == monitor_level_label_reg_r[31:16]
       && reg_grp == monitor_level_label_reg_r[47:40]))
      else $error("instr side field wrong");
   vid_bound_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      {1'b0, vid_reduced} <= vmax)
      else $error("virtual id not reduced");
   no_valid_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (use_virt && reg_pid <= pid_max && virt_map_valid_bits_r == 32'h0)
      |-> rsp_out.err)
      else $error("no valid entry without error");
   pass_thru_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (!use_virt && reg_pid <= pid_max)
      |-> (rsp_out.pid == reg_pid && !rsp_out.err))
      else $error("physical id not passed");
endmodule

// *** verification/label_requester.sv ***
// model of the processor access path that presents label requests
`timescale 1ns/1ps
module label_requester (
   // clock
   input  wire logic                    clk_sys_in,
   // request toward the selector
   output label_select_pkg::label_req_s req_out
);
   import label_select_pkg::*;

   // ------------------------------------------------------------
   // request driver
   // ------------------------------------------------------------
   // held between calls: a real access path keeps its request level
   initial begin
      req_out = '0;
   end

   // a 2-bit level field means only levels 0 to 3 can be asked for
   task automatic present(input logic [1:0] lvl, input logic side,
                          input logic perr);
      @(posedge clk_sys_in);
      req_out <= '{level: lvl, instr_side_select: side,
                   prior_err: perr};
      @(negedge clk_sys_in);
   endtask
endmodule

// *** verification/tb_partition_label_select.sv ***
// self-checking bench for the partition label selector
`timescale 1ns/1ps
`include "label_select_map.svh"
module tb_partition_label_select;
   import label_select_pkg::*;

   // ------------------------------------------------------------
   // clock, reset and design signals
   // ------------------------------------------------------------
   logic        clk_sys_in   = 1'b0;
   logic        sys_rst_in   = 1'b1;
   logic [7:0]  address_in   = 8'h00;
   logic        read_in      = 1'b0;
   logic        write_in     = 1'b0;
   logic [31:0] writedata_in = 32'h0000_0000;
   logic [31:0] readdata_out;
   logic        waitrequest_out;
   label_req_s  req_in;
   label_rsp_s  rsp_out;
   logic [31:0] rd;
   int          n_errors     = 0;
   int          n_checks     = 0;
   int          lvl;
   int          sd;
   int          n;

   // 10 MHz system clock
   always #50 clk_sys_in = ~clk_sys_in;

   partition_label_select dut (
      .clk_sys_in      (clk_sys_in),
      .sys_rst_in      (sys_rst_in),
      .address_in      (address_in),
      .read_in         (read_in),
      .write_in        (write_in),
      .writedata_in    (writedata_in),
      .readdata_out    (readdata_out),
      .waitrequest_out (waitrequest_out),
      .req_in          (req_in),
      .rsp_out         (rsp_out)
   );

   label_requester req_model (
      .clk_sys_in (clk_sys_in),
      .req_out    (req_in)
   );

   // ------------------------------------------------------------
   // report and compare tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value readdata expected %h seen %h", exp, got);
      end
   endtask

   task automatic chk_label(input logic [15:0] pid, input logic [7:0] grp,
                            input logic err);
      n_checks++;
      if (rsp_out !== {pid, grp, err}) begin
         n_errors++;
         $display("wrong value labels expected %h %h %b seen %h %h %b",
                  pid, grp, err, rsp_out.pid, rsp_out.grp, rsp_out.err);
      end
   endtask

   task automatic chk_grp(input logic [7:0] grp);
      n_checks++;
      if (rsp_out.grp !== grp) begin
         n_errors++;
         $display("wrong value group expected %h seen %h", grp, rsp_out.grp);
      end
   endtask

   // ------------------------------------------------------------
   // avalon-mm master
   // ------------------------------------------------------------
   // waitrequest and read data are taken at the rising edge itself, and
   // the request is dropped right after the edge that saw waitrequest low
   task automatic bus_access(input logic wr, input logic [7:0] addr,
                             input logic [31:0] data,
                             output logic [31:0] q);
      int k;
      @(posedge clk_sys_in);
      address_in   <= addr;
      writedata_in <= data;
      write_in     <= wr;
      read_in      <= ~wr;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_sys_in);
         if (waitrequest_out === 1'b0) break;
      end
      if (k == 20) begin
         n_errors++;
         tally_and_finish();
      end
      q = readdata_out;
      write_in <= 1'b0;
      read_in  <= 1'b0;
   endtask

   task automatic wr32(input logic [7:0] addr, input logic [31:0] data);
      bus_access(1'b1, addr, data, rd);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
      bus_access(1'b0, addr, 32'h0000_0000, rd);
      chk_word(exp, rd);
   endtask

   // ------------------------------------------------------------
   // label request helpers
   // ------------------------------------------------------------
   task automatic label_chk(input logic [1:0] l, input logic s,
                            input logic [15:0] pid, input logic [7:0] grp,
                            input logic err);
      req_model.present(l, s, 1'b0);
      chk_label(pid, grp, err);
   endtask

   // kernel data id carries the virtual id; errors drop the group too
   task automatic vcase(input logic [15:0] vid, input logic [15:0] pid,
                        input logic err);
      wr32(`OFS_KER_LO, {16'h1001, vid});
      label_chk(2'd1, 1'b0, pid, err ? 8'h00 : 8'h21, err);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      rd_chk(`OFS_FEAT, 32'h07ff_ffff);
      rd_chk(`OFS_CTRL, 32'h0000_0000);
      wr32(8'h30, 32'hffff_ffff);
      rd_chk(8'h30, 32'h0000_0000);
      // level l label words sit at 8*(3-l)
      for (lvl = 0; lvl < 4; lvl++) begin
         wr32(8'(8 * (3 - lvl)), {16'h1000 + 16'(lvl), 16'h2000 + 16'(lvl)});
         wr32(8'(8 * (3 - lvl) + 4),
              {16'h0, 8'h40 + 8'(lvl), 8'h20 + 8'(lvl)});
      end
      rd_chk(`OFS_KER_LO, 32'h1001_2001);
      wr32(`OFS_CTRL, 32'h0000_0001);
      for (lvl = 0; lvl < 4; lvl++) begin
         for (sd = 0; sd < 2; sd++) begin
            label_chk(2'(lvl), sd[0], 16'((sd ? 16'h1000 : 16'h2000) + lvl),
                      8'((sd ? 8'h40 : 8'h20) + lvl),
                      1'b0);
         end
      end
      // hypervisor level disabled reads as zero labels
      wr32(`OFS_CTRL, 32'h0000_0000);
      label_chk(2'd2, 1'b0, 16'h0000, 8'h00, 1'b0);
      label_chk(2'd2, 1'b1, 16'h0000, 8'h00, 1'b0);
      wr32(`OFS_CTRL, 32'h0000_0001);
      req_model.present(2'd1, 1'b0, 1'b1);
      chk_grp(8'h00);
      // group maximum at 0x21: boundary passes, above it defaults
      wr32(`OFS_FEAT, 32'h0721_ffff);
      label_chk(2'd1, 1'b0, 16'h2001, 8'h21, 1'b0);
      label_chk(2'd2, 1'b0, 16'h2002, 8'h00, 1'b0);
      label_chk(2'd1, 1'b1, 16'h1001, 8'h00, 1'b0);
      // id maximum at 0x2001
      wr32(`OFS_FEAT, 32'h07ff_2001);
      label_chk(2'd1, 1'b0, 16'h2001, 8'h21, 1'b0);
      label_chk(2'd2, 1'b0, 16'h0000, 8'h00, 1'b1);
      wr32(`OFS_FEAT, 32'h07ff_ffff);
      // map entry for virtual id v holds 0x0a00 + v
      for (n = 0; n < 8; n++) begin
         wr32(8'(8'h40 + 8 * n),
              {16'h0a01 + 16'(4 * n), 16'h0a00 + 16'(4 * n)});
         wr32(8'(8'h44 + 8 * n),
              {16'h0a03 + 16'(4 * n), 16'h0a02 + 16'(4 * n)});
      end
      rd_chk(8'h48, 32'h0a05_0a04);
      wr32(`OFS_VALID, 32'hffff_ffff);
      wr32(`OFS_CTRL, 32'h0000_0003);
      vcase(16'd5, 16'h0a05, 1'b0);
      vcase(16'd30, 16'h0a1e, 1'b0);
      vcase(16'd33, 16'h0a01, 1'b0);
      label_chk(2'd3, 1'b0, 16'h2003, 8'h23, 1'b0);
      wr32(`OFS_VALID, 32'hffff_ffbf);
      vcase(16'd6, 16'h0a00, 1'b0);
      wr32(`OFS_VALID, 32'hffff_ffbe);
      vcase(16'd6, 16'h0000, 1'b1);
      wr32(`OFS_VALID, 32'hffff_ffff);
      wr32(`OFS_FEAT, 32'h07ff_0a04);
      vcase(16'd5, 16'h0000, 1'b1);
      // no valid entry at all
      wr32(`OFS_VALID, 32'h0000_0000);
      vcase(16'd3, 16'h0000, 1'b1);
      wr32(`OFS_VALID, 32'hffff_ffff);
      // count field 1 leaves virtual ids 0 to 7
      wr32(`OFS_FEAT, 32'h01ff_ffff);
      vcase(16'd9, 16'h0a01, 1'b0);
      tally_and_finish();
   end
endmodule
